/* mhb_pkg.sv */
// Package for the parallel host port: access types, bus styles and reset filter count.
// Assumes a single 50 MHz reference clock shared by both ends.
package mhb_pkg;
  // Bus style select values.
  localparam logic STYLE_8080 = 1'h0;
  localparam logic STYLE_6800 = 1'h1;
  localparam logic STYLE_AUX_REQ = 1'h0;
  // Register select values.
  localparam logic SEL_STATUS_OR_DATA = 1'h0;
  localparam logic SEL_DATA_OR_CMD = 1'h1;
  // Direction line values in 6800 style.
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  // Data bus width.
  localparam int DATA_W = 8;
  // Clock period and reset noise filter.
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_FILTER_NS = 60;
  localparam int RESET_FILTER_CYC = (RESET_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host strobe phase lengths in cycles.
  localparam int HOST_SETUP_CYC = 2;
  localparam int HOST_STROBE_CYC = 4;
  localparam int HOST_HOLD_CYC = 2;
  // Access kinds decoded from select and strobes.
  typedef enum logic [1:0] {
    ACC_STATUS_RD = 2'h0,
    ACC_DATA_RD = 2'h1,
    ACC_DATA_WR = 2'h2,
    ACC_CMD_WR = 2'h3
  } mhb_acc_e;
endpackage : mhb_pkg

/* mhb_if.sv */
// Interface carrying the host pins between the host end and the device end.
// Resolves the shared data bus here from the two enables, with the device end taking priority.
`timescale 1ns/1ps
interface mhb_if;
  import mhb_pkg::*;
  logic busStyleSelect;
  logic busStyleSelectAux;
  logic chipSelN;
  logic registerSelect;
  logic readEnable;
  logic writeDir;
  logic hardwareResetIn;
  logic [DATA_W-1:0] hostDataHostOut;
  logic hostDataHostOe;
  logic [DATA_W-1:0] hostDataDevOut;
  logic hostDataDevOe;
  logic [DATA_W-1:0] hostDataBus;
  // Wire level of the shared bus; pull-ups read as all ones when nobody drives.
  assign hostDataBus = hostDataDevOe ? hostDataDevOut :
                       (hostDataHostOe ? hostDataHostOut : {DATA_W{1'b1}});
  modport host (
    output busStyleSelect, busStyleSelectAux, chipSelN, registerSelect,
    output readEnable, writeDir, hardwareResetIn, hostDataHostOut, hostDataHostOe,
    input hostDataBus
  );
  modport device (
    input busStyleSelect, busStyleSelectAux, chipSelN, registerSelect,
    input readEnable, writeDir, hardwareResetIn, hostDataBus,
    output hostDataDevOut, hostDataDevOe
  );
endinterface : mhb_if

/* mhb_device.sv */
// Device end of the parallel host port: decodes host accesses and serves reads.
// Assumes the host pins are asynchronous to ref_clk and pass through synchronisers.
//
// Operation
// R01: Style select 0 gives 8080, 1 gives 6800.
// R02: 8080 read pin is an active-low strobe.
// R03: Drive data only while read is asserted.
// R04: 6800 read pin is active-high enable clock.
// R05: 8080 write data captured at strobe rise.
// R06: 6800 write pin high reads, low writes.
// R07: Respond only while chip select is asserted.
// R08: 8080 decode from select and strobes.
// R09: 6800 decode with enable high.
// R10: Eight-line bidirectional tristate data bus.
// R11: Reset input performs full reset, noise filtered; the filtered reset only raises coreReset and blocks the strobes.
// R12: 6800 write captured at enable falling edge.
`timescale 1ns/1ps
module mhb_device
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Host pins.
  mhb_if.device pins,
  // User side: read data supplied by the controller core.
  input wire logic [mhb_pkg::DATA_W-1:0] statusIn,
  input wire logic [mhb_pkg::DATA_W-1:0] readDataIn,
  // User side: decoded accesses.
  output logic wrStrobe,
  output logic wrIsCommand,
  output logic [mhb_pkg::DATA_W-1:0] wrData,
  output logic rdStrobe,
  output logic rdIsData,
  output logic styleErr,
  output logic coreReset
);
  import mhb_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [1:0] csS;
    logic [1:0] rsS;
    logic [1:0] reS;
    logic [1:0] wrS;
    logic [1:0] hwRstS;
    logic [DATA_W-1:0] dS1;
    logic [DATA_W-1:0] dS2;
    logic reD;
    logic wrD;
    logic rsD;
    logic [DATA_W-1:0] dD;
    logic [7:0] hwRstCnt;
    logic wrStb;
    logic wrCmd;
    logic [DATA_W-1:0] wrDat;
    logic rdStb;
    logic rdDat;
    logic [DATA_W-1:0] outDat;
    logic coreRst;
  } mhb_dev_s;

  mhb_dev_s state_r;
  mhb_dev_s state_nxt;
  logic is6800;
  logic rdActive;

  // Decode an access type from select and direction.
  function automatic mhb_acc_e decodeAcc(input logic sel, input logic isRead);
    if (isRead)
      decodeAcc = (sel == SEL_STATUS_OR_DATA) ? ACC_STATUS_RD : ACC_DATA_RD;
    else
      decodeAcc = (sel == SEL_STATUS_OR_DATA) ? ACC_DATA_WR : ACC_CMD_WR;
  endfunction : decodeAcc

  // Style straps are static, so they are read directly.
  assign is6800 = (pins.busStyleSelect == STYLE_6800); // see R01

  // Output drive is combinational from the pins so it tracks the strobe without delay.
  always_comb
  begin
    if (is6800)
      rdActive = !pins.chipSelN && pins.readEnable && (pins.writeDir == DIR_READ); // see R04
    else
      rdActive = !pins.chipSelN && !pins.readEnable; // see R02
  end
  assign pins.hostDataDevOe = rdActive; // see R03
  assign pins.hostDataDevOut = state_r.outDat; // see R10

  //////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    logic reEdgeEnd;
    logic isWrite;
    logic cs;
    mhb_acc_e acc;
    reEdgeEnd = 1'b0;
    isWrite = 1'b0;
    cs = 1'b0;
    acc = ACC_STATUS_RD;
    state_nxt = state_r;
    // Two-flop synchronisers; only the second stage feeds logic.
    state_nxt.csS = {state_r.csS[0], pins.chipSelN};
    state_nxt.rsS = {state_r.rsS[0], pins.registerSelect};
    state_nxt.reS = {state_r.reS[0], pins.readEnable};
    state_nxt.wrS = {state_r.wrS[0], pins.writeDir};
    state_nxt.hwRstS = {state_r.hwRstS[0], pins.hardwareResetIn};
    state_nxt.dS1 = pins.hostDataBus;
    state_nxt.dS2 = state_r.dS1;
    state_nxt.reD = state_r.reS[1];
    state_nxt.wrD = state_r.wrS[1];
    state_nxt.rsD = state_r.rsS[1];
    state_nxt.dD = state_r.dS2;
    state_nxt.wrStb = 1'b0;
    state_nxt.rdStb = 1'b0;
    cs = !state_r.csS[1];
    // A reset level must persist a few cycles so short glitches are ignored.
    if (state_r.hwRstS[1])
    begin
      if (state_r.hwRstCnt < 8'(RESET_FILTER_CYC))
        state_nxt.hwRstCnt = state_r.hwRstCnt + 8'h01;
    end
    else
      state_nxt.hwRstCnt = 8'h00;
    state_nxt.coreRst = (state_r.hwRstCnt >= 8'(RESET_FILTER_CYC)); // see R11
    if (is6800)
    begin
      // Enable falling edge closes the cycle; direction and data sampled one stage back.
      reEdgeEnd = state_r.reD && !state_r.reS[1];
      isWrite = (state_r.wrD == DIR_WRITE); // see R06
      acc = decodeAcc(state_r.rsD, !isWrite); // see R09
      if (reEdgeEnd && cs && isWrite) // see R12
      begin
        state_nxt.wrStb = 1'b1;
        state_nxt.wrCmd = (acc == ACC_CMD_WR);
        state_nxt.wrDat = state_r.dD;
      end
      if (!state_r.reD && state_r.reS[1] && cs && (state_r.wrS[1] == DIR_READ))
      begin
        state_nxt.rdStb = 1'b1;
        state_nxt.rdDat = (decodeAcc(state_r.rsS[1], 1'b1) == ACC_DATA_RD);
      end
    end
    else
    begin
      // Write strobe rising edge latches the data held one stage back.
      if (!state_r.wrD && state_r.wrS[1] && cs) // see R05
      begin
        acc = decodeAcc(state_r.rsD, 1'b0); // see R08
        state_nxt.wrStb = 1'b1;
        state_nxt.wrCmd = (acc == ACC_CMD_WR);
        state_nxt.wrDat = state_r.dD;
      end
      if (state_r.reD && !state_r.reS[1] && cs) // see R07
      begin
        state_nxt.rdStb = 1'b1;
        state_nxt.rdDat = (decodeAcc(state_r.rsS[1], 1'b1) == ACC_DATA_RD);
      end
    end
    // Read data follows the select line so it is valid as soon as the strobe opens.
    state_nxt.outDat = (pins.registerSelect == SEL_STATUS_OR_DATA) ? statusIn : readDataIn;
    if (state_r.coreRst)
    begin
      state_nxt.wrStb = 1'b0;
      state_nxt.rdStb = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register stage.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign wrStrobe = state_r.wrStb;
  assign wrIsCommand = state_r.wrCmd;
  assign wrData = state_r.wrDat;
  assign rdStrobe = state_r.rdStb;
  assign rdIsData = state_r.rdDat;
  assign coreReset = state_r.coreRst | rst;
  assign styleErr = (pins.busStyleSelectAux != STYLE_AUX_REQ); // see R01
endmodule : mhb_device

/* mhb_host.sv */
// Host end of the parallel host port: runs one strobe cycle per request.
// Assumes the device end samples pins on its own clock with a two-cycle lag.
`timescale 1ns/1ps
module mhb_host
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Host pins.
  mhb_if.host pins,
  // User side configuration.
  input wire logic use6800,
  input wire logic resetReq,
  // User side request.
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqSel,
  input wire logic [mhb_pkg::DATA_W-1:0] reqData,
  output logic reqReady,
  // User side answer.
  output logic rspValid,
  output logic [mhb_pkg::DATA_W-1:0] rspData
);
  import mhb_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_SETUP = 4'h2,
    H_STROBE = 4'h4,
    H_HOLD = 4'h8
  } mhb_hst_e;

  typedef struct packed {
    mhb_hst_e st;
    logic [3:0] cnt;
    logic wr;
    logic sel;
    logic [DATA_W-1:0] dat;
    logic rspV;
    logic [DATA_W-1:0] rspD;
  } mhb_hst_s;

  mhb_hst_s state_r;
  mhb_hst_s state_nxt;
  logic strobeOn;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: setup, strobe and hold phases give the device time to synchronise.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.rspV = 1'b0;
    case (state_r.st)
      H_IDLE:
        if (reqValid)
        begin
          state_nxt.st = H_SETUP;
          state_nxt.cnt = 4'h0;
          state_nxt.wr = reqWrite;
          state_nxt.sel = reqSel;
          state_nxt.dat = reqData;
        end
      H_SETUP:
        if (state_r.cnt == 4'(HOST_SETUP_CYC - 1))
        begin
          state_nxt.st = H_STROBE;
          state_nxt.cnt = 4'h0;
        end
        else
          state_nxt.cnt = state_r.cnt + 4'h1;
      H_STROBE:
        if (state_r.cnt == 4'(HOST_STROBE_CYC - 1))
        begin
          state_nxt.st = H_HOLD;
          state_nxt.cnt = 4'h0;
          // Read data sampled just before the strobe closes.
          if (!state_r.wr)
          begin
            state_nxt.rspV = 1'b1;
            state_nxt.rspD = pins.hostDataBus;
          end
        end
        else
          state_nxt.cnt = state_r.cnt + 4'h1;
      H_HOLD:
        if (state_r.cnt == 4'(HOST_HOLD_CYC - 1))
          state_nxt.st = H_IDLE;
        else
          state_nxt.cnt = state_r.cnt + 4'h1;
      default:
        state_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= '0;
      state_r.st <= H_IDLE;
    end
    else
      state_r <= state_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive.
  assign strobeOn = (state_r.st == H_STROBE);
  assign pins.busStyleSelect = use6800 ? STYLE_6800 : STYLE_8080; // see R01
  assign pins.busStyleSelectAux = STYLE_AUX_REQ; // see R01
  assign pins.chipSelN = (state_r.st == H_IDLE); // see R07
  assign pins.registerSelect = state_r.sel;
  assign pins.hardwareResetIn = resetReq; // see R11
  // 8080 strobes are active low; 6800 uses enable high and a direction line.
  assign pins.readEnable = use6800 ? strobeOn : !(strobeOn && !state_r.wr); // see R02, R04
  assign pins.writeDir = use6800 ? !state_r.wr : !(strobeOn && state_r.wr); // see R06
  // Data is held through hold so the device sees it at the closing edge.
  assign pins.hostDataHostOe = state_r.wr && (state_r.st != H_IDLE); // see R10
  assign pins.hostDataHostOut = state_r.dat;
  assign reqReady = (state_r.st == H_IDLE);
  assign rspValid = state_r.rspV;
  assign rspData = state_r.rspD;
endmodule : mhb_host

/* mhb_assertions.sv */
// Checker for the host pin interface between the host end and the device end.
// Assumes it is instantiated beside the interface and sees its signals unchanged.
`timescale 1ns/1ps
module mhb_assertions
  import mhb_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Host pins.
  input wire logic busStyleSelect,
  input wire logic busStyleSelectAux,
  input wire logic chipSelN,
  input wire logic registerSelect,
  input wire logic readEnable,
  input wire logic writeDir,
  input wire logic hardwareResetIn,
  // Data bus drivers.
  input wire logic [DATA_W-1:0] hostDataHostOut,
  input wire logic hostDataHostOe,
  input wire logic [DATA_W-1:0] hostDataDevOut,
  input wire logic hostDataDevOe,
  input wire logic [DATA_W-1:0] hostDataBus
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Read cycles of each bus style, selected and with the strobe active.
  sequence rd8080_s;
    !busStyleSelect && !chipSelN && !readEnable && writeDir;
  endsequence
  sequence rd6800_s;
    busStyleSelect && !chipSelN && readEnable && writeDir;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // Bus ownership: the device only drives inside a read, never against the host.
  dev_read_only_a: assert property (hostDataDevOe |-> (rd8080_s or rd6800_s))
    else $error("device drives the data bus outside a read");
  read_drive8080_a: assert property (rd8080_s |-> hostDataDevOe)
    else $error("device silent during a read strobe");
  read_drive6800_a: assert property (rd6800_s |-> hostDataDevOe)
    else $error("device silent during an enable read");
  deselect_quiet_a: assert property (chipSelN |-> !hostDataDevOe)
    else $error("device drives while not selected");
  bus_no_fight_a: assert property (!(hostDataDevOe && hostDataHostOe))
    else $error("both ends drive the data bus");
  aux_style_low_a: assert property (busStyleSelectAux == STYLE_AUX_REQ)
    else $error("auxiliary style select not low");
  // A write presents data on the bus for the whole strobe, so the capture edge sees it.
  write_data_held_a: assert property (!chipSelN && !writeDir
      && (!busStyleSelect || readEnable) |-> hostDataHostOe && $stable(hostDataHostOut))
    else $error("write data not held during strobe");
  // Strobe phases are long enough for the device synchronisers.
  strobe8080_len_a: assert property ($fell(readEnable) && !chipSelN && !busStyleSelect
      |-> (!readEnable) [*3] ##[1:2] readEnable)
    else $error("read strobe length wrong");
  enable6800_len_a: assert property ($rose(readEnable) && !chipSelN && busStyleSelect
      |-> readEnable [*3] ##[1:2] !readEnable)
    else $error("enable pulse length wrong");
endmodule : mhb_assertions

/* testbench.sv */
// Self-checking bench joining the host end and the device end through the pin interface.
// Assumes a 50 MHz clock and the host strobe phases of the package.
`timescale 1ns/1ps
module testbench;
  import mhb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic use6800 = 1'b0;
  logic resetReq = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic reqSel = 1'b0;
  logic [DATA_W-1:0] reqData = 8'h00;
  logic [DATA_W-1:0] statusIn = 8'h00;
  logic [DATA_W-1:0] readDataIn = 8'h00;
  logic reqReady, rspValid, wrStrobe, wrIsCommand, rdStrobe, rdIsData, styleErr, coreReset;
  logic [DATA_W-1:0] rspData, wrData;
  logic seen;
  int fails = 0;
  int compares = 0;
  int rdq[$];
  int evq[$];

  mhb_if u_mhb_if ();
  mhb_host u_mhb_host (.ref_clk(ref_clk), .rst(rst), .pins(u_mhb_if.host), .use6800(use6800),
    .resetReq(resetReq), .reqValid(reqValid), .reqWrite(reqWrite), .reqSel(reqSel),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
  mhb_device u_mhb_device (.ref_clk(ref_clk), .rst(rst), .pins(u_mhb_if.device),
    .statusIn(statusIn), .readDataIn(readDataIn), .wrStrobe(wrStrobe),
    .wrIsCommand(wrIsCommand), .wrData(wrData), .rdStrobe(rdStrobe), .rdIsData(rdIsData),
    .styleErr(styleErr), .coreReset(coreReset));
  mhb_assertions u_mhb_assertions (.ref_clk(ref_clk), .rst(rst),
    .busStyleSelect(u_mhb_if.busStyleSelect), .busStyleSelectAux(u_mhb_if.busStyleSelectAux),
    .chipSelN(u_mhb_if.chipSelN), .registerSelect(u_mhb_if.registerSelect),
    .readEnable(u_mhb_if.readEnable), .writeDir(u_mhb_if.writeDir),
    .hardwareResetIn(u_mhb_if.hardwareResetIn), .hostDataHostOut(u_mhb_if.hostDataHostOut),
    .hostDataHostOe(u_mhb_if.hostDataHostOe), .hostDataDevOut(u_mhb_if.hostDataDevOut),
    .hostDataDevOe(u_mhb_if.hostDataDevOe), .hostDataBus(u_mhb_if.hostDataBus));

  // Free-running reference clock.
  always #10 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports it at once when it fails.
  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok)
    begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // One host access; the model queues what both user sides must show for it.
  task automatic xfer(input bit w, input bit s);
    logic [7:0] d;
    logic [7:0] st;
    logic [7:0] rd;
    d = 8'($urandom);
    st = 8'($urandom);
    rd = 8'($urandom);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqSel <= s;
    reqData <= d;
    for (int n = 0; n < 40 && reqReady !== 1'b1; n++)
      @(negedge ref_clk);
    check(reqReady === 1'b1, "host never ready");
    // Read sources change only at the take edge, so an earlier read still in flight keeps its byte.
    @(posedge ref_clk);
    statusIn <= st;
    readDataIn <= rd;
    reqValid <= 1'b0;
    if (w)
      evq.push_back(512 + 256 * s + d);
    else
    begin
      evq.push_back(s);
      rdq.push_back(s ? rd : st);
    end
  endtask : xfer

  // Raises the reset request for n cycles and notes whether the core reset was seen.
  task automatic pulse(input int n, output logic hit);
    hit = 1'b0;
    for (int k = 0; k < 20; k++)
    begin
      @(posedge ref_clk);
      resetReq <= (k < n);
      @(negedge ref_clk);
      hit = hit | coreReset;
    end
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  // Compares user-side results with the model on settled values at the falling edge.
  always @(negedge ref_clk)
  begin
    if (!rst && rspValid === 1'b1)
      check(rdq.size() > 0 && rspData === 8'(rdq.pop_front()), "read data");
    if (!rst && wrStrobe === 1'b1)
      check(evq.size() > 0 && {1'b1, wrIsCommand, wrData} === 10'(evq.pop_front()),
        "write access");
    if (!rst && rdStrobe === 1'b1)
      check(evq.size() > 0 && {1'b0, rdIsData} === 2'(evq.pop_front()), "read kind");
    if (!rst && styleErr !== 1'b0)
      check(1'b0, "style error raised");
  end

  // Main sequence: both bus styles, every access kind, then the reset filter.
  initial
  begin
    void'($urandom(32'h2337f129));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      @(posedge ref_clk);
      use6800 <= m[0];
      repeat (12) @(posedge ref_clk);
      for (int i = 0; i < 16; i++)
        xfer((i < 4) ? i[1] : 1'($urandom), (i < 4) ? i[0] : 1'($urandom));
      repeat (20) @(posedge ref_clk);
      check(evq.size() == 0 && rdq.size() == 0, "access lost");
      $display("test bus style %0d done", m);
    end
    pulse(1, seen);
    check(seen === 1'b0, "short reset pulse not filtered");
    pulse(6, seen);
    check(seen === 1'b1, "reset not applied");
    check(coreReset === 1'b0, "reset not released");
    $display("test hardware reset done");
    end_of_test();
  end

  // Watchdog well beyond the expected run length.
  initial
  begin
    #(20 * 5000);
    check(1'b0, "watchdog expired");
    end_of_test();
  end
endmodule : testbench
